// ==== rtl/timer8_defines.svh ====
/*
 * Register offsets, field positions, reset values and divider masks of the
 * 8-bit waveform timer. Assumes a byte-addressed AXI4-Lite bus, one word per register.
 */
`ifndef TIMER8_DEFINES_SVH
`define TIMER8_DEFINES_SVH

// Register byte offsets
`define OFS_OUT_MODE_CTRL   8'h00
`define OFS_CLOCK_CTRL      8'h04
`define OFS_TIMER_COUNT     8'h08
`define OFS_COMPARE_A       8'h0C
`define OFS_COMPARE_B       8'h10
`define OFS_FLAGS           8'h14

// Output mode control fields
`define OMC_MODE_A_HI       7
`define OMC_MODE_A_LO       6
`define OMC_MODE_B_HI       5
`define OMC_MODE_B_LO       4
`define OMC_WGM_HI          1
`define OMC_WGM_LO          0
`define OMC_WRITE_MASK      8'hF3

// Clock control fields
`define CLK_FORCE_A         7
`define CLK_FORCE_B         6
`define CLK_WGM_HIGH        3
`define CLK_SEL_HI          2
`define CLK_SEL_LO          0
`define CLK_KEEP_MASK       8'h0F

// Flag bits
`define FLG_OVERFLOW        0
`define FLG_COMPARE_A       1
`define FLG_COMPARE_B       2

// Reset values
`define RST_CTRL            8'h00
`define RST_COUNT           8'h00
`define RST_COMPARE         8'h00

// Counter levels
`define CNT_BOTTOM          8'h00
`define CNT_MAX             8'hFF

// Wave generation modes
`define WGM_NORMAL          3'h0
`define WGM_PC_FF           3'h1
`define WGM_CTC             3'h2
`define WGM_FAST_FF         3'h3
`define WGM_PC_OCA          3'h5
`define WGM_FAST_OCA        3'h7

// Prescaler masks: tick when all masked divider bits are ones
`define DIV_WIDTH           10
`define DIV8_MASK           10'h007
`define DIV32_MASK          10'h01F
`define DIV64_MASK          10'h03F
`define DIV128_MASK         10'h07F
`define DIV256_MASK         10'h0FF
`define DIV1024_MASK        10'h3FF

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// ==== rtl/timer8_pkg.sv ====
/*
 * Types shared by the waveform timer files.
 * Assumes timer8_defines.svh supplies the numeric constants.
 */
package timer8_pkg;

    // Counting direction of the dual-slope counter
    typedef enum logic {
        DIR_UP,
        DIR_DOWN
    } count_dir_t;

endpackage

// ==== rtl/tick_divider.sv ====
/*
 * Prescaler: turns the core clock into a one-cycle timer tick enable.
 * Assumes the select code is a register of the core clock domain.
 */
`timescale 1ns/10ps
`include "timer8_defines.svh"

module tick_divider (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [2:0] tick_source_select,
    output logic            timer_tick
);

    logic [`DIV_WIDTH-1:0] div_reg;
    logic [`DIV_WIDTH-1:0] div_next;
    logic [`DIV_WIDTH-1:0] mask;

    // Free-running divider, held at zero while stopped
    always_comb begin
        if (tick_source_select == 3'h0) begin
            div_next = '0;
        end else begin
            div_next = div_reg + `DIV_WIDTH'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // Select decode: stop, undivided, 8, 32, 64, 128, 256, 1024
    always_comb begin
        case (tick_source_select)
            3'h2:    mask = `DIV8_MASK;
            3'h3:    mask = `DIV32_MASK;
            3'h4:    mask = `DIV64_MASK;
            3'h5:    mask = `DIV128_MASK;
            3'h6:    mask = `DIV256_MASK;
            3'h7:    mask = `DIV1024_MASK;
            default: mask = '0;
        endcase
        if (tick_source_select == 3'h0) begin
            timer_tick = 1'b0;
        end else if (tick_source_select == 3'h1) begin
            timer_tick = 1'b1;
        end else begin
            timer_tick = ((div_reg & mask) == mask);
        end
    end

endmodule

// ==== rtl/timer8_wave.sv ====
/*
 * 8-bit timer with two compare channels, normal, clear-on-match, fast and
 * phase correct PWM, reached over AXI4-Lite.
 * Assumes a single core clock; pin direction logic sits outside and uses
 * the wave enables as the port override.
 */
// Local design decisions: the address map and the AXI4-Lite slave port.
// Functional notes
// - Phase correct counts up to TOP, holds TOP one tick, then counts down.
// - Phase correct sets the overflow flag whenever the counter reaches BOTTOM.
// - Phase correct code 10: clear on up-count match, set on down-count match.
// - Phase correct code 11: set on up-count match, clear on down-count match.
// - Phase correct period is 510 ticks at TOP 0xFF; tick is prescaled clock.
// - Compare at BOTTOM holds low, at MAX holds high, inverted mode opposite.
// - At TOP output takes the up-count match level for symmetry about BOTTOM.
// - Non-PWM codes: disconnected, toggle, clear, set on compare match.
// - Fast PWM code 10 clears on match, sets at TOP; 11 the reverse.
// - Channel A code 01 in PWM toggles only when mode high bit is set.
// - Channel B follows channel A except code 01 is reserved in PWM.
// - Compare value equal to TOP with high code bit acts at TOP only.
// - Nonzero output code overrides the pin; software sets pin direction.
// - Output mode register bits 3 and 2 always read zero.
// - Mode field decodes normal, phase PWM, CTC, fast PWM; 5 and 7 use compare A.
// - Compare update immediate in non-PWM, at TOP in PWM; overflow point per mode.
// - Counter advances only on cycles carrying the timer tick enable.
// - Select zero stops the counter; others choose 1, 8, 32, 64, 128, 256, 1024.
// - Force strobe applies output action in non-PWM, no flag, reads zero.
`timescale 1ns/10ps
`include "timer8_defines.svh"

module timer8_wave #(
    parameter int ADDR_W = 8
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RESET,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    output logic                   WAVE_OUT_A,
    output logic                   WAVE_OUT_B,
    output logic                   WAVE_EN_A,
    output logic                   WAVE_EN_B,
    output logic                   OVERFLOW_FLAG,
    output logic                   COMPARE_FLAG_A,
    output logic                   COMPARE_FLAG_B
);

    // Bus state
    logic              aw_full_reg, aw_full_next;
    logic              w_full_reg, w_full_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic [7:0]        w_data_reg, w_data_next;
    logic              w_lane_reg, w_lane_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic              wr_do;
    logic              wr_hit;
    logic              rd_hit;
    logic [7:0]        rd_val;

    // Timer state
    logic [7:0]            omc_reg, omc_next;
    logic [7:0]            clk_reg, clk_next;
    logic [7:0]            timer_count_reg, timer_count_next;
    logic [7:0]            buf_a_reg, buf_a_next;
    logic [7:0]            buf_b_reg, buf_b_next;
    logic [7:0]            act_a_reg, act_a_next;
    logic [7:0]            act_b_reg, act_b_next;
    logic [2:0]            flags_reg, flags_next;
    logic                  block_reg, block_next;
    logic                  wave_a_reg, wave_a_next;
    logic                  wave_b_reg, wave_b_next;
    timer8_pkg::count_dir_t dir_reg, dir_next;

    logic       timer_tick;
    logic [2:0] wave_gen_mode;
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic       is_pwm, is_pc, top_is_a;
    logic [7:0] top_val;
    logic       hit_a, hit_b, at_top, ovf_evt;
    logic       force_a, force_b;

    tick_divider u_div (
        .clk                (CORE_CLK),
        .reset              (RESET),
        .tick_source_select (clk_reg[`CLK_SEL_HI:`CLK_SEL_LO]),
        .timer_tick         (timer_tick)
    );

    // Next output level of one channel for the current cycle
    function automatic logic wave_step(
        input logic       cur,
        input logic [1:0] code,
        input logic       pwm,
        input logic       pc,
        input logic       toggle_ok,
        input logic       hit,
        input logic       ocr_top,
        input logic       ocr_bot,
        input logic       new_top,
        input logic       top_evt,
        input logic       up,
        input logic       force_hit
    );
        logic r;
        logic up_lvl;
        r = cur;
        up_lvl = code[0];
        if (!pwm) begin
            if (hit || force_hit) begin
                case (code)
                    2'h1:    r = ~cur;
                    2'h2:    r = 1'b0;
                    2'h3:    r = 1'b1;
                    default: r = cur;
                endcase
            end
        end else if (code == 2'h1) begin
            if (toggle_ok && hit) begin
                r = ~cur;
            end
        end else if (code[1]) begin
            if (pc) begin
                if (hit && !ocr_top && !ocr_bot) begin
                    r = up ? up_lvl : ~up_lvl;
                end
                if (top_evt) begin
                    r = new_top ? ~up_lvl : up_lvl;
                end
                if (ocr_bot) begin
                    r = up_lvl;
                end
            end else begin
                if (hit && !ocr_top) begin
                    r = up_lvl;
                end
                if (top_evt) begin
                    r = ~up_lvl;
                end
            end
        end
        return r;
    endfunction

    // Mode decode
    always_comb begin
        wave_gen_mode = {clk_reg[`CLK_WGM_HIGH], omc_reg[`OMC_WGM_HI:`OMC_WGM_LO]};
        out_mode_a = omc_reg[`OMC_MODE_A_HI:`OMC_MODE_A_LO];
        out_mode_b = omc_reg[`OMC_MODE_B_HI:`OMC_MODE_B_LO];
        is_pc = (wave_gen_mode == `WGM_PC_FF) || (wave_gen_mode == `WGM_PC_OCA);
        is_pwm = is_pc || (wave_gen_mode == `WGM_FAST_FF) || (wave_gen_mode == `WGM_FAST_OCA);
        top_is_a = (wave_gen_mode == `WGM_CTC) || (wave_gen_mode == `WGM_PC_OCA)
                   || (wave_gen_mode == `WGM_FAST_OCA);
        top_val = top_is_a ? act_a_reg : `CNT_MAX;
        hit_a = timer_tick && !block_reg && (timer_count_reg == act_a_reg);
        hit_b = timer_tick && !block_reg && (timer_count_reg == act_b_reg);
        at_top = timer_tick && (timer_count_reg == top_val)
                 && (!is_pc || dir_reg == timer8_pkg::DIR_UP);
        force_a = wr_hit && (aw_addr_reg == `OFS_CLOCK_CTRL) && w_data_reg[`CLK_FORCE_A] && !is_pwm;
        force_b = wr_hit && (aw_addr_reg == `OFS_CLOCK_CTRL) && w_data_reg[`CLK_FORCE_B] && !is_pwm;
    end

    // Counter, direction, compare buffers, outputs and flags
    always_comb begin
        timer_count_next = timer_count_reg;
        dir_next = dir_reg;
        omc_next = omc_reg;
        clk_next = clk_reg;
        buf_a_next = buf_a_reg;
        buf_b_next = buf_b_reg;
        act_a_next = act_a_reg;
        act_b_next = act_b_reg;
        block_next = block_reg;
        ovf_evt = 1'b0;
        if (timer_tick) begin
            block_next = 1'b0;
            if (is_pc) begin
                if (dir_reg == timer8_pkg::DIR_UP) begin
                    if (timer_count_reg == top_val) begin
                        dir_next = timer8_pkg::DIR_DOWN;
                        if (top_val != `CNT_BOTTOM) begin
                            timer_count_next = timer_count_reg - 8'h01;
                        end
                    end else begin
                        timer_count_next = timer_count_reg + 8'h01;
                    end
                end else if (timer_count_reg == `CNT_BOTTOM) begin
                    dir_next = timer8_pkg::DIR_UP;
                    if (top_val != `CNT_BOTTOM) begin
                        timer_count_next = 8'h01;
                    end
                end else begin
                    timer_count_next = timer_count_reg - 8'h01;
                    ovf_evt = (timer_count_reg == 8'h01);
                end
            end else begin
                dir_next = timer8_pkg::DIR_UP;
                if ((wave_gen_mode != `WGM_NORMAL) && (timer_count_reg == top_val)) begin
                    timer_count_next = `CNT_BOTTOM;
                end else begin
                    timer_count_next = timer_count_reg + 8'h01;
                end
                if (wave_gen_mode == `WGM_FAST_OCA) begin
                    ovf_evt = at_top;
                end else begin
                    ovf_evt = (timer_count_reg == `CNT_MAX);
                end
            end
        end
        // Register writes from the bus
        if (wr_hit) begin
            case (aw_addr_reg)
                `OFS_OUT_MODE_CTRL: omc_next = w_data_reg & `OMC_WRITE_MASK;
                `OFS_CLOCK_CTRL:    clk_next = w_data_reg & `CLK_KEEP_MASK;
                `OFS_TIMER_COUNT: begin
                    timer_count_next = w_data_reg;
                    block_next = 1'b1;
                end
                `OFS_COMPARE_A:     buf_a_next = w_data_reg;
                `OFS_COMPARE_B:     buf_b_next = w_data_reg;
                default: begin
                end
            endcase
        end
        // Compare buffers load at once outside PWM, at TOP within it
        if (!is_pwm) begin
            act_a_next = buf_a_next;
            act_b_next = buf_b_next;
        end else if (at_top) begin
            act_a_next = buf_a_reg;
            act_b_next = buf_b_reg;
        end
        wave_a_next = wave_step(wave_a_reg, out_mode_a, is_pwm, is_pc, clk_reg[`CLK_WGM_HIGH],
                                hit_a, act_a_reg == top_val, act_a_reg == `CNT_BOTTOM,
                                act_a_next == (top_is_a ? act_a_next : `CNT_MAX), at_top,
                                dir_reg == timer8_pkg::DIR_UP, force_a);
        wave_b_next = wave_step(wave_b_reg, out_mode_b, is_pwm, is_pc, 1'b0,
                                hit_b, act_b_reg == top_val, act_b_reg == `CNT_BOTTOM,
                                act_b_next == (top_is_a ? act_a_next : `CNT_MAX), at_top,
                                dir_reg == timer8_pkg::DIR_UP, force_b);
        // Sticky flags: an event in the clearing cycle wins
        flags_next = flags_reg;
        if (wr_hit && aw_addr_reg == `OFS_FLAGS) begin
            flags_next = flags_reg & ~w_data_reg[2:0];
        end
        if (ovf_evt) begin
            flags_next[`FLG_OVERFLOW] = 1'b1;
        end
        if (hit_a) begin
            flags_next[`FLG_COMPARE_A] = 1'b1;
        end
        if (hit_b) begin
            flags_next[`FLG_COMPARE_B] = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            omc_reg <= `RST_CTRL;
            clk_reg <= `RST_CTRL;
            timer_count_reg <= `RST_COUNT;
            buf_a_reg <= `RST_COMPARE;
            buf_b_reg <= `RST_COMPARE;
            act_a_reg <= `RST_COMPARE;
            act_b_reg <= `RST_COMPARE;
            flags_reg <= 3'h0;
            block_reg <= 1'b0;
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
            dir_reg <= timer8_pkg::DIR_UP;
        end else begin
            omc_reg <= omc_next;
            clk_reg <= clk_next;
            timer_count_reg <= timer_count_next;
            buf_a_reg <= buf_a_next;
            buf_b_reg <= buf_b_next;
            act_a_reg <= act_a_next;
            act_b_reg <= act_b_next;
            flags_reg <= flags_next;
            block_reg <= block_next;
            wave_a_reg <= wave_a_next;
            wave_b_reg <= wave_b_next;
            dir_reg <= dir_next;
        end
    end

    // Read mux; force strobes and reserved bits read zero
    always_comb begin
        rd_hit = 1'b1;
        case (S_AXI_ARADDR)
            `OFS_OUT_MODE_CTRL: rd_val = omc_reg;
            `OFS_CLOCK_CTRL:    rd_val = clk_reg;
            `OFS_TIMER_COUNT:   rd_val = timer_count_reg;
            `OFS_COMPARE_A:     rd_val = buf_a_reg;
            `OFS_COMPARE_B:     rd_val = buf_b_reg;
            `OFS_FLAGS:         rd_val = {5'h00, flags_reg};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
        wr_hit = 1'b0;
        case (aw_addr_reg)
            `OFS_OUT_MODE_CTRL, `OFS_CLOCK_CTRL, `OFS_TIMER_COUNT,
            `OFS_COMPARE_A, `OFS_COMPARE_B, `OFS_FLAGS: wr_hit = wr_do && w_lane_reg;
            default: wr_hit = 1'b0;
        endcase
    end

    // AXI4-Lite handshake: address and data taken in either order
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
        if (S_AXI_AWVALID && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = S_AXI_WDATA[7:0];
            w_lane_next = S_AXI_WSTRB[0];
        end
        if (wr_do) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_hit || !w_lane_reg) && (aw_addr_reg <= `OFS_FLAGS)
                         && (aw_addr_reg[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_next = 1'b0;
        end
        if (S_AXI_ARVALID && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = {24'h000000, rd_val};
            rresp_next = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `RESP_OKAY;
            rdata_reg <= 32'h00000000;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // Port drive; any nonzero code claims the pin
    always_comb begin
        S_AXI_AWREADY = !aw_full_reg;
        S_AXI_WREADY = !w_full_reg;
        S_AXI_BVALID = bvalid_reg;
        S_AXI_BRESP = bresp_reg;
        S_AXI_ARREADY = !rvalid_reg;
        S_AXI_RVALID = rvalid_reg;
        S_AXI_RRESP = rresp_reg;
        S_AXI_RDATA = rdata_reg;
        WAVE_OUT_A = wave_a_reg;
        WAVE_OUT_B = wave_b_reg;
        WAVE_EN_A = (omc_reg[`OMC_MODE_A_HI:`OMC_MODE_A_LO] != 2'h0);
        WAVE_EN_B = (omc_reg[`OMC_MODE_B_HI:`OMC_MODE_B_LO] != 2'h0);
        OVERFLOW_FLAG = flags_reg[`FLG_OVERFLOW];
        COMPARE_FLAG_A = flags_reg[`FLG_COMPARE_A];
        COMPARE_FLAG_B = flags_reg[`FLG_COMPARE_B];
    end

endmodule

// ==== dv/timer8_wave_asserts.sv ====
/* Port checker for timer8_wave bus answers, pin override and flag clearing.
   Assumes binding to every timer8_wave instance. */
`timescale 1ns/10ps
module timer8_wave_asserts (
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        WAVE_EN_A,
    input wire logic        OVERFLOW_FLAG
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // Read channel answers and holds
    property p_rd_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_rd_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
    property p_rd_drop; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
    a_rd_drop: assert property (p_rd_drop) else $error("read answer repeated");
    property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_ar_block: assert property (p_ar_block) else $error("second read taken");
    property p_hi_zero; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
    // Pin override changes and sticky flag clears only with a write
    property p_pin_ovr; !$past(RESET) && $changed(WAVE_EN_A) |-> $rose(S_AXI_BVALID); endproperty
    a_pin_ovr: assert property (p_pin_ovr) else $error("override without write");
    property p_ovf_keep; !$past(RESET) && $fell(OVERFLOW_FLAG) |-> $rose(S_AXI_BVALID); endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("flag lost");
    property p_ovf_once; $rose(OVERFLOW_FLAG) |=> OVERFLOW_FLAG [*2]; endproperty
    a_ovf_once: assert property (p_ovf_once) else $error("flag not sticky");
endmodule
bind timer8_wave timer8_wave_asserts u_timer8_wave_asserts (.*);

// ==== dv/pwm_pin_load.sv ====
/* Pin load model for one wave output.
   Assumes a pull-down while the pin is not driven. */
`timescale 1ns/10ps
module pwm_pin_load (
    input  wire logic wave,
    input  wire logic wave_en,
    input  wire logic dir_out,
    output logic      pin
);
    // Wave reaches the pin only with override and output direction
    assign pin = (wave_en && dir_out) ? wave : 1'b0;
endmodule

// ==== dv/timer8_wave_tb.sv ====
/* Bench for timer8_wave: bus tasks, pin timing, verdict.
   Assumes the pin load model and the bound checker. */
`timescale 1ns/10ps
`include "timer8_defines.svh"
module timer8_wave_tb;
    logic CORE_CLK = 1'b0, RESET = 1'b1, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, WAVE_OUT_A, WAVE_OUT_B, WAVE_EN_A, WAVE_EN_B, OVERFLOW_FLAG, COMPARE_FLAG_A, COMPARE_FLAG_B;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, cmp;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
    logic pin_a;
    int miscompares, samples_checked, per, hi;
    timer8_wave u_timer8_wave (.*);
    pwm_pin_load u_pwm_pin_load (.wave(WAVE_OUT_A), .wave_en(WAVE_EN_A), .dir_out(1'b1), .pin(pin_a));
    // Clock
    always #2 CORE_CLK = ~CORE_CLK;
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // One bus transfer, a write when w is set
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tr, t;
        @(posedge CORE_CLK);
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= {a, a, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} <= {w, w, w, !w, !w};
        do begin
            @(negedge CORE_CLK);
            {ta, tw, tr} = {S_AXI_AWREADY & S_AXI_AWVALID, S_AXI_WREADY & S_AXI_WVALID, S_AXI_ARREADY & S_AXI_ARVALID};
            {t, rd, rr} = {w ? S_AXI_BVALID : S_AXI_RVALID, S_AXI_RDATA, w ? S_AXI_BRESP : S_AXI_RRESP};
            @(posedge CORE_CLK);
            {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} <= {S_AXI_AWVALID & !ta, S_AXI_WVALID & !tw, S_AXI_ARVALID & !tr};
        end while (!t);
        {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
    endtask
    // Period and high time between two rising pin edges
    task automatic meas(input int s);
        repeat (s) @(negedge CORE_CLK);
        for (int p = 0; p < 4; p++) begin
            if (p == 2) {per, hi} = 64'h0;
            while (pin_a !== p[0]) begin
                @(negedge CORE_CLK);
                per++;
                hi += pin_a;
            end
        end
    endtask
    // Expected high time in phase correct mode
    function automatic int exp_hi(input logic [7:0] c, input logic inv);
        return inv ? 510 - 2 * c : 2 * c;
    endfunction
    // Verdict
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge CORE_CLK);
        miscompares++;
        report_and_stop;
    end
    // Tests
    initial begin
        void'($urandom(32'h1D7D3975));
        cmp = 8'($urandom_range(254, 1));
        repeat (12) @(posedge CORE_CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 24; i += 4) begin
            bus(1'b0, 8'(i), 32'h0);
            chk(rd, 32'h0);
        end
        bus(1'b1, `OFS_OUT_MODE_CTRL, 32'hFF);
        chk(rr, `RESP_OKAY);
        bus(1'b0, `OFS_OUT_MODE_CTRL, 32'h0);
        chk(rd, 32'hF3);
        bus(1'b0, 8'h40, 32'h0);
        chk(rr, `RESP_SLVERR);
        // Force strobes with the counter stopped: set, then clear
        for (int k = 1; k >= 0; k--) begin
            bus(1'b1, `OFS_OUT_MODE_CTRL, k ? 32'hC0 : 32'h80);
            bus(1'b1, `OFS_CLOCK_CTRL, 32'h80);
            bus(1'b0, `OFS_CLOCK_CTRL, 32'h0);
            chk(rd, 32'h0);
            chk({pin_a, COMPARE_FLAG_A}, {k[0], 1'b0});
        end
        // Toggle in normal mode, tick every cycle
        bus(1'b1, `OFS_OUT_MODE_CTRL, 32'h40);
        bus(1'b1, `OFS_CLOCK_CTRL, 32'h01);
        meas(4);
        chk(per, 512);
        // Phase correct, random compare on A, B held at BOTTOM, both polarities
        bus(1'b1, `OFS_COMPARE_A, {24'h000000, cmp});
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `OFS_OUT_MODE_CTRL, k ? 32'hF1 : 32'hA1);
            meas(1100);
            chk(per, 510);
            chk(hi, exp_hi(cmp, k[0]));
            chk({WAVE_EN_B, WAVE_OUT_B, COMPARE_FLAG_B}, {1'b1, k[0], 1'b1});
        end
        // Overflow flag returns after clearing
        bus(1'b1, `OFS_FLAGS, 32'h1);
        repeat (520) @(negedge CORE_CLK);
        chk(OVERFLOW_FLAG, 1'b1);
        // Divide by eight stretches the period
        bus(1'b1, `OFS_CLOCK_CTRL, 32'h02);
        meas(9000);
        chk(per, 4080);
        report_and_stop;
    end
endmodule
